//--- src/i2c_master_irq_error_regs.sv
/*
 * Register slice of a two-wire bus master on an APB slave port: interrupt
 * enables with set and disable views, event status, error sources,
 * peripheral enable, and the received byte count.
 * Assumes the bus engine drives its event strobes as one-cycle pulses
 * synchronous to mclk and that the APB master keeps each request steady.
 */
`timescale 1ns/1ns
module i2c_master_irq_error_regs (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic halt_done_event,
    input wire logic paused_event,
    input wire logic receive_begun_event,
    input wire logic transmit_begun_event,
    input wire logic final_receive_event,
    input wire logic final_transmit_event,
    input wire logic rx_byte_arrive,
    input wire logic rx_byte_moved,
    input wire logic address_nack,
    input wire logic data_nack,
    output logic irq,
    output logic master_enable
);

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [6:0] int_en;
        logic [3:0] periph_en;
        logic master_enable;
        logic irq;
    } state_t;

    state_t state;
    state_t next_state;

    logic [6:0] ev_set;
    logic [6:0] ev_clear;
    logic [6:0] ev_flags;
    logic [2:0] err_set;
    logic [2:0] err_clear;
    logic [2:0] err_flags;
    logic answer;
    logic wr_take;
    logic mapped;
    logic [31:0] rd_word;

    rx_track_if trk ();

    ////////////////////////////////////////////////////////////////////////
    // Receive tracking and sticky flags.

    assign trk.byte_arrive = rx_byte_arrive;
    assign trk.byte_moved = rx_byte_moved;
    assign trk.xfer_begin = receive_begun_event;
    assign trk.data_nack = data_nack;

    rx_tracker u_tracker (
        .mclk(mclk),
        .rst_n(rst_n),
        .trk(trk.tracker)
    );

    always_comb
    begin
        err_set = 3'h0;
        err_set[i2c_regs_pkg::ERR_OVERRUN] = trk.overrun;
        err_set[i2c_regs_pkg::ERR_ADDRESS_NACK] = address_nack;
        err_set[i2c_regs_pkg::ERR_DATA_NACK] = data_nack;
    end

    always_comb
    begin
        ev_set = 7'h00;
        ev_set[i2c_regs_pkg::EV_HALT_DONE] = halt_done_event;
        ev_set[i2c_regs_pkg::EV_ERROR] = |err_set;
        ev_set[i2c_regs_pkg::EV_PAUSED] = paused_event;
        ev_set[i2c_regs_pkg::EV_RECEIVE_BEGUN] = receive_begun_event;
        ev_set[i2c_regs_pkg::EV_TRANSMIT_BEGUN] = transmit_begun_event;
        ev_set[i2c_regs_pkg::EV_FINAL_RECEIVE] = final_receive_event;
        ev_set[i2c_regs_pkg::EV_FINAL_TRANSMIT] = final_transmit_event;
    end

    sticky_flags #(
        .WIDTH(i2c_regs_pkg::NUM_EVENTS)
    ) u_events (
        .mclk(mclk),
        .rst_n(rst_n),
        .set(ev_set),
        .clear(ev_clear),
        .flags(ev_flags)
    );

    sticky_flags #(
        .WIDTH(i2c_regs_pkg::NUM_ERRORS)
    ) u_errors (
        .mclk(mclk),
        .rst_n(rst_n),
        .set(err_set),
        .clear(err_clear),
        .flags(err_flags)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB decode.

    // The slave answers one cycle into the access phase; the write lands at
    // the edge where pready is seen high, which is the only edge the master
    // holds the request for certain.
    assign answer = psel & penable & ~state.pready;
    assign wr_take = psel & penable & state.pready & pwrite;

    always_comb
    begin
        mapped = 1'b1;
        rd_word = i2c_regs_pkg::RST_WORD;
        case (paddr)
            i2c_regs_pkg::OFF_EVENT_STATUS:
                rd_word[6:0] = ev_flags;
            i2c_regs_pkg::OFF_INT_ENABLE_SET:
                rd_word[6:0] = state.int_en;
            i2c_regs_pkg::OFF_INTERRUPT_DISABLE:
                rd_word[6:0] = state.int_en;
            i2c_regs_pkg::OFF_ERROR_SOURCE:
                rd_word[2:0] = err_flags;
            i2c_regs_pkg::OFF_PERIPHERAL_ENABLE:
                rd_word[3:0] = state.periph_en;
            i2c_regs_pkg::OFF_BYTES_MOVED_COUNT:
                rd_word[13:0] = trk.count;
            default:
                mapped = 1'b0;
        endcase
    end

    always_comb
    begin
        ev_clear = 7'h00;
        err_clear = 3'h0;
        if (wr_take && paddr == i2c_regs_pkg::OFF_EVENT_STATUS)
            ev_clear = pwdata[6:0];
        if (wr_take && paddr == i2c_regs_pkg::OFF_ERROR_SOURCE)
            err_clear = pwdata[2:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Register state.

    always_comb
    begin
        next_state = state;
        next_state.pready = answer;
        next_state.pslverr = answer & ~mapped;
        if (answer)
            next_state.prdata = pwrite ? i2c_regs_pkg::RST_WORD : rd_word;
        if (wr_take && paddr == i2c_regs_pkg::OFF_INT_ENABLE_SET)
            next_state.int_en = state.int_en | pwdata[6:0];
        if (wr_take && paddr == i2c_regs_pkg::OFF_INTERRUPT_DISABLE)
            next_state.int_en = state.int_en & ~pwdata[6:0];
        if (wr_take && paddr == i2c_regs_pkg::OFF_PERIPHERAL_ENABLE)
            next_state.periph_en = pwdata[3:0];
        next_state.master_enable = next_state.periph_en != 4'h0;
        next_state.irq = |(ev_flags & state.int_en);
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state <= '0;
            state.int_en <= i2c_regs_pkg::RST_INT_ENABLE;
            state.periph_en <= i2c_regs_pkg::RST_PERIPHERAL_ENABLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign prdata = state.prdata;
    assign pready = state.pready;
    assign pslverr = state.pslverr;
    assign irq = state.irq;
    assign master_enable = state.master_enable;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    disable_first_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (wr_take && paddr == i2c_regs_pkg::OFF_INTERRUPT_DISABLE)
        |=> (state.int_en[2:0] & $past(pwdata[2:0])) == 3'h0)
        else $error("disable write left an enable set");

    disable_rest_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (wr_take && paddr == i2c_regs_pkg::OFF_INTERRUPT_DISABLE)
        |=> (state.int_en[6:3] & $past(pwdata[6:3])) == 4'h0)
        else $error("disable write left an enable set");

    readback_en_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (answer && !pwrite && paddr == i2c_regs_pkg::OFF_INTERRUPT_DISABLE)
        |=> prdata[6:0] == $past(state.int_en))
        else $error("disable view did not read the enables");

    set_readback_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (answer && !pwrite && paddr == i2c_regs_pkg::OFF_INT_ENABLE_SET)
        |=> prdata[6:0] == $past(state.int_en))
        else $error("set view did not read the enables");

    overrun_flag_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        trk.overrun |=> err_flags[i2c_regs_pkg::ERR_OVERRUN])
        else $error("overrun not flagged");

    addr_nack_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        address_nack |=> err_flags[i2c_regs_pkg::ERR_ADDRESS_NACK])
        else $error("address nack not flagged");

    addr_clear_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (wr_take && paddr == i2c_regs_pkg::OFF_ERROR_SOURCE
            && pwdata[1] && !address_nack)
        |=> !err_flags[i2c_regs_pkg::ERR_ADDRESS_NACK])
        else $error("address nack flag not cleared");

    nack_clear_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (wr_take && paddr == i2c_regs_pkg::OFF_ERROR_SOURCE
            && pwdata[2] && !data_nack)
        |=> !err_flags[i2c_regs_pkg::ERR_DATA_NACK])
        else $error("data nack flag not cleared");

    data_nack_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        data_nack |=> err_flags[i2c_regs_pkg::ERR_DATA_NACK])
        else $error("data nack not flagged");

    enable_off_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (wr_take && paddr == i2c_regs_pkg::OFF_PERIPHERAL_ENABLE
            && pwdata[3:0] == 4'h0)
        |=> !master_enable ##1 !master_enable)
        else $error("master still enabled after zero write");

    enable_on_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (wr_take && paddr == i2c_regs_pkg::OFF_PERIPHERAL_ENABLE
            && pwdata[3:0] != 4'h0)
        |=> master_enable)
        else $error("master not enabled after nonzero write");

    enable_set_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (wr_take && paddr == i2c_regs_pkg::OFF_INT_ENABLE_SET)
        |=> (state.int_en & $past(pwdata[6:0])) == $past(pwdata[6:0]))
        else $error("set write did not enable");

    nack_count_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (data_nack && !receive_begun_event
            && trk.count != i2c_regs_pkg::COUNT_MAX)
        |=> trk.count == $past(trk.count) + 14'h0001)
        else $error("nacked byte not counted");

    count_read_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (answer && !pwrite && paddr == i2c_regs_pkg::OFF_BYTES_MOVED_COUNT)
        |=> prdata[13:0] == $past(trk.count))
        else $error("byte count not read back");

    count_restart_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        receive_begun_event |=> trk.count == i2c_regs_pkg::RST_COUNT)
        else $error("byte count not restarted");

    error_event_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (address_nack || data_nack || trk.overrun)
        |=> ev_flags[i2c_regs_pkg::EV_ERROR])
        else $error("error event not raised");

    irq_level_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ((ev_flags & state.int_en) != 7'h00) |=> irq)
        else $error("interrupt not raised");

    irq_quiet_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ((ev_flags & state.int_en) == 7'h00) |=> !irq)
        else $error("interrupt raised with nothing pending");

    // The answer is fixed at one wait state, so a master may rely on it.
    access_answer_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (psel && penable && !pready) |=> pready)
        else $error("access phase not answered");

    ready_pulse_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        pready |=> !pready)
        else $error("ready held beyond one cycle");

    slverr_unmapped_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (answer && !mapped) |=> pslverr)
        else $error("unmapped access not refused");

    write_rdata_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (answer && pwrite) |=> prdata == 32'h0000_0000)
        else $error("write answered with read data");

endmodule // i2c_master_irq_error_regs

//--- src/i2c_regs_pkg.sv
/*
 * Constants shared by the two-wire bus master register slice: register
 * offsets, field positions, widths and reset values.
 * Assumes a 12-bit APB byte address and 32-bit data words.
 */
package i2c_regs_pkg;

    localparam int ADDR_W = 12;
    localparam int NUM_EVENTS = 7;
    localparam int NUM_ERRORS = 3;
    localparam int ENABLE_W = 4;
    localparam int COUNT_W = 14;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [11:0] OFF_EVENT_STATUS = 12'h100;
    localparam logic [11:0] OFF_INT_ENABLE_SET = 12'h304;
    localparam logic [11:0] OFF_INTERRUPT_DISABLE = 12'h308;
    localparam logic [11:0] OFF_ERROR_SOURCE = 12'h4c4;
    localparam logic [11:0] OFF_PERIPHERAL_ENABLE = 12'h500;
    localparam logic [11:0] OFF_BYTES_MOVED_COUNT = 12'h53c;

    ////////////////////////////////////////////////////////////////////////
    localparam int EV_HALT_DONE = 0;
    localparam int EV_ERROR = 1;
    localparam int EV_PAUSED = 2;
    localparam int EV_RECEIVE_BEGUN = 3;
    localparam int EV_TRANSMIT_BEGUN = 4;
    localparam int EV_FINAL_RECEIVE = 5;
    localparam int EV_FINAL_TRANSMIT = 6;

    localparam int ERR_OVERRUN = 0;
    localparam int ERR_ADDRESS_NACK = 1;
    localparam int ERR_DATA_NACK = 2;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [6:0] RST_INT_ENABLE = 7'h00;
    localparam logic [3:0] RST_PERIPHERAL_ENABLE = 4'h0;
    localparam logic [13:0] RST_COUNT = 14'h0000;
    localparam logic [13:0] COUNT_MAX = 14'h3fff;

endpackage

//--- src/rx_track_if.sv
/*
 * Carrier between the register slice and its receive tracker.
 * Assumes all signals are synchronous to mclk of the owner.
 */
`timescale 1ns/1ns
interface rx_track_if;
    logic byte_arrive;
    logic byte_moved;
    logic xfer_begin;
    logic data_nack;
    logic overrun;
    logic [13:0] count;

    modport tracker (
        input byte_arrive,
        input byte_moved,
        input xfer_begin,
        input data_nack,
        output overrun,
        output count
    );
    modport owner (
        output byte_arrive,
        output byte_moved,
        output xfer_begin,
        output data_nack,
        input overrun,
        input count
    );
endinterface

//--- src/sticky_flags.sv
/*
 * A row of sticky flags: a pulse sets a bit, a one on clear drops it.
 * Assumes set and clear are single-cycle pulses synchronous to mclk.
 */
`timescale 1ns/1ns
module sticky_flags #(
    parameter int WIDTH = 3
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clear,
    output logic [WIDTH-1:0] flags
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } state_t;

    state_t state;
    state_t next_state;

    // Set wins over a clear in the same cycle so no event is lost.
    always_comb
    begin
        next_state = state;
        next_state.flags = set | (state.flags & ~clear);
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            state <= '0;
        else
            state <= next_state;
    end

    assign flags = state.flags;

    set_wins_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (set != '0) |=> ((flags & $past(set)) == $past(set)))
        else $error("sticky flag lost its set");

endmodule // sticky_flags

//--- src/rx_tracker.sv
/*
 * Receive tracker: flags a byte that arrives while the previous one still
 * waits, and counts bytes moved or refused with a data nack in the current transfer.
 * Assumes the bus engine pulses its strobes for one mclk cycle.
 */
`timescale 1ns/1ns
module rx_tracker (
    input wire logic mclk,
    input wire logic rst_n,
    rx_track_if.tracker trk
);

    typedef struct packed {
        logic pending;
        logic overrun;
        logic [13:0] count;
    } state_t;

    state_t state;
    state_t next_state;
    logic step;

    always_comb
    begin
        next_state = state;
        step = trk.byte_moved | trk.data_nack;
        next_state.overrun = trk.byte_arrive & state.pending & ~trk.byte_moved;
        next_state.pending = trk.byte_arrive
            | (state.pending & ~trk.byte_moved);
        if (trk.xfer_begin)
            next_state.count = i2c_regs_pkg::RST_COUNT;
        else if (step && state.count != i2c_regs_pkg::COUNT_MAX)
            next_state.count = state.count + 14'h0001;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            state <= '0;
        else
            state <= next_state;
    end

    assign trk.overrun = state.overrun;
    assign trk.count = state.count;

    early_byte_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (trk.byte_arrive && state.pending && !trk.byte_moved)
        |=> trk.overrun)
        else $error("early byte not flagged");

endmodule // rx_tracker

//--- bench/i2c_slave_model.sv
/*
 * Far side model: a slave on the two-wire bus, reduced to the strobes
 * that reach the register slice.
 * Assumes its tasks are called at a rising mclk edge.
 */
`timescale 1ns/1ns
module i2c_slave_model (
    input wire logic mclk,
    output logic address_nack,
    output logic data_nack,
    output logic rx_byte_arrive,
    output logic rx_byte_moved
);
    logic [3:0] strobe = 4'h0;

    assign {rx_byte_moved, rx_byte_arrive, data_nack, address_nack} = strobe;

    ////////////////////////////////////////////////////////////////////////
    // Strobes last one cycle; the gap lets the slave answer slowly.
    task automatic answer(input logic [3:0] m, input int gap);
        strobe <= m;
        @(posedge mclk);
        strobe <= 4'h0;
        repeat (gap + 1) @(posedge mclk);
    endtask

    task automatic refuse_address(input int gap);
        answer(4'h1, gap);
    endtask

    task automatic refuse_data(input int gap);
        answer(4'h2, gap);
    endtask
endmodule // i2c_slave_model

//--- bench/i2c_master_irq_error_regs_tb.sv
/*
 * Self-checking bench for the register slice: APB master tasks, event
 * strobes and a slave model.
 * Assumes the slice answers every APB access within the timeout.
 */
`timescale 1ns/1ns
module i2c_master_irq_error_regs_tb;
    localparam logic [11:0] A_SET = i2c_regs_pkg::OFF_INT_ENABLE_SET;
    localparam logic [11:0] A_CLR = i2c_regs_pkg::OFF_INTERRUPT_DISABLE;
    localparam logic [11:0] A_STAT = i2c_regs_pkg::OFF_EVENT_STATUS;
    localparam logic [11:0] A_ERR = i2c_regs_pkg::OFF_ERROR_SOURCE;
    localparam logic [11:0] A_EN = i2c_regs_pkg::OFF_PERIPHERAL_ENABLE;
    localparam logic [11:0] A_CNT = i2c_regs_pkg::OFF_BYTES_MOVED_COUNT;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic master_enable, slverr_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] ev;
    logic address_nack, data_nack, rx_byte_arrive, rx_byte_moved;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;

    i2c_master_irq_error_regs u_i2c_master_irq_error_regs (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .halt_done_event(ev[0]),
        .paused_event(ev[1]), .receive_begun_event(ev[2]),
        .transmit_begun_event(ev[3]), .final_receive_event(ev[4]),
        .final_transmit_event(ev[5]), .rx_byte_arrive(rx_byte_arrive),
        .rx_byte_moved(rx_byte_moved), .address_nack(address_nack),
        .data_nack(data_nack), .irq(irq), .master_enable(master_enable)
    );

    i2c_slave_model u_i2c_slave_model (
        .mclk(mclk), .address_nack(address_nack), .data_nack(data_nack),
        .rx_byte_arrive(rx_byte_arrive), .rx_byte_moved(rx_byte_moved)
    );

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // A hung handshake would otherwise stall the run forever.
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            finish_test;
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, want, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        slverr_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a,
                          input logic [31:0] want);
        apb(1'b0, a, 32'h0000_0000);
        check(name, rd, want);
    endtask

    task automatic pulse(input logic [5:0] m);
        ev <= m;
        @(posedge mclk);
        ev <= 6'h00;
        repeat (3) @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        int b;
        logic [31:0] want;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ev = 6'h00;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        check("master_enable", {31'h0000_0000, master_enable}, 0);
        rd_chk("disable reset", A_CLR, 32'h0000_0000);
        rd_chk("errors reset", A_ERR, 32'h0000_0000);
        rd_chk("enable reset", A_EN, 32'h0000_0000);
        apb(1'b1, A_SET, 32'h0000_007f);
        rd_chk("set view", A_SET, 32'h0000_007f);
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, A_CLR, 32'h0000_0001 << i);
            want = (32'h0000_007f >> (i + 1)) << (i + 1);
            apb(1'b0, A_CLR, 32'h0000_0000);
            if (i < 3)
                check("disable view", rd, want);
            else
                check("disable view", rd, want);
        end
        rd_chk("set view off", A_SET, 32'h0000_0000);
        for (int i = 0; i < 6; i++)
        begin
            b = (i == 0) ? 0 : i + 1;
            apb(1'b1, A_SET, 32'h0000_0001 << b);
            pulse(6'h01 << i);
            check("irq raised", {31'h0000_0000, irq}, 1);
            rd_chk("status", A_STAT, 32'h0000_0001 << b);
            apb(1'b1, A_CLR, 32'h0000_0001 << b);
            repeat (2) @(posedge mclk);
            check("irq masked", {31'h0000_0000, irq}, 0);
            apb(1'b1, A_STAT, 32'h0000_0001 << b);
        end
        apb(1'b1, A_SET, 32'h0000_0002);
        u_i2c_slave_model.refuse_address(0);
        rd_chk("address nack", A_ERR, 32'h0000_0002);
        check("error irq", {31'h0000_0000, irq}, 1);
        apb(1'b1, A_ERR, 32'h0000_0002);
        rd_chk("address nack off", A_ERR, 32'h0000_0000);
        rd_chk("error event", A_STAT, 32'h0000_0002);
        apb(1'b1, A_STAT, 32'h0000_0002);
        u_i2c_slave_model.refuse_data(3);
        rd_chk("data nack", A_ERR, 32'h0000_0004);
        rd_chk("error event", A_STAT, 32'h0000_0002);
        apb(1'b1, A_ERR, 32'h0000_0004);
        rd_chk("data nack off", A_ERR, 32'h0000_0000);
        // A byte moved in time must not count as lost.
        u_i2c_slave_model.answer(4'h4, 0);
        u_i2c_slave_model.answer(4'h8, 0);
        u_i2c_slave_model.answer(4'h4, 0);
        rd_chk("no overrun", A_ERR, 32'h0000_0000);
        u_i2c_slave_model.answer(4'h4, 2);
        rd_chk("overrun", A_ERR, 32'h0000_0001);
        apb(1'b1, A_ERR, 32'h0000_0001);
        pulse(6'h04);
        u_i2c_slave_model.answer(4'h8, 0);
        u_i2c_slave_model.answer(4'h4, 0);
        u_i2c_slave_model.answer(4'h8, 1);
        u_i2c_slave_model.refuse_data(0);
        rd_chk("byte count", A_CNT, 32'h0000_0003);
        apb(1'b1, A_CNT, 32'h0000_ffff);
        check("count write error", {31'h0000_0000, slverr_seen}, 0);
        rd_chk("count kept", A_CNT, 32'h0000_0003);
        apb(1'b1, A_EN, 32'h0000_0005);
        rd_chk("enable field", A_EN, 32'h0000_0005);
        check("mapped error", {31'h0000_0000, slverr_seen}, 0);
        check("master on", {31'h0000_0000, master_enable}, 1);
        apb(1'b1, A_EN, 32'hffff_ffff);
        rd_chk("enable width", A_EN, 32'h0000_000f);
        apb(1'b1, A_EN, 32'h0000_0000);
        repeat (2) @(posedge mclk);
        check("master off", {31'h0000_0000, master_enable}, 0);
        rd_chk("unmapped data", 12'h004, 32'h0000_0000);
        check("unmapped error", {31'h0000_0000, slverr_seen}, 1);
        finish_test;
    end
endmodule // i2c_master_irq_error_regs_tb
